//--- core/adc_output_demux_ctrl.sv
// output demultiplexer of a fast 8-bit sampling converter with apb control
// Functional notes
// - Samples are taken on the rising sample clock edge.
// - The active output ports update when the strobe clock rises.
// - Strobe falls near the middle of the valid data window.
// - Each port has eight bits, each with true and complement outputs.
// - Half rate puts two consecutive samples on both ports per strobe.
// - Single-port mode bypasses the demux, primary port only.
// - Second port powers down under two separate enables.
// - Quarter rate drops every other sample, pairs the kept ones.
// - In demux modes overrange flags either port's overranged sample.
// - In single-port mode overrange follows the primary sample only.
// - Sync reset input holds the demux in reset while asserted.
// - Differential reset output follows the internal demux reset.
// - Undriven sync reset input leaves the reset disabled.
// - Port order never depends on strobe phase.
`timescale 1ns/1ps
module adc_output_demux_ctrl (
  input wire logic pclk, // sample clock, 100 MHz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [adc_demux_pkg::ADDR_W-1:0] paddr, // apb byte address
  input wire logic [adc_demux_pkg::DATA_W-1:0] pwdata, // apb write data
  output logic [adc_demux_pkg::DATA_W-1:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic sample_valid, // converter sample present
  input wire logic [adc_demux_pkg::SAMPLE_W-1:0] sample_data, // converter sample
  input wire logic sample_overrange, // sample overranged
  input wire logic sync_reset_input_true, // reset pin, true phase
  input wire logic sync_reset_input_comp, // reset pin, complementary phase
  output logic [adc_demux_pkg::SAMPLE_W-1:0] first_port_bits_true, // primary port true
  output logic [adc_demux_pkg::SAMPLE_W-1:0] first_port_bits_comp, // primary port complement
  output logic [adc_demux_pkg::SAMPLE_W-1:0] second_port_bits_true, // second port true
  output logic [adc_demux_pkg::SAMPLE_W-1:0] second_port_bits_comp, // second port complement
  output logic overrange_true, // overrange true
  output logic overrange_comp, // overrange complement
  output logic output_strobe_clock_true, // data-ready strobe true
  output logic output_strobe_clock_comp, // data-ready strobe complement
  output logic sync_reset_output_true, // reset out true
  output logic sync_reset_output_comp // reset out complement
);

  typedef struct packed {
    adc_demux_pkg::rate_mode_t mode;
    logic pair_phase;
    logic drop_phase;
    logic [adc_demux_pkg::SAMPLE_W-1:0] held_data;
    logic held_over;
    logic [adc_demux_pkg::SAMPLE_W-1:0] first_true;
    logic [adc_demux_pkg::SAMPLE_W-1:0] first_comp;
    logic [adc_demux_pkg::SAMPLE_W-1:0] second_true;
    logic [adc_demux_pkg::SAMPLE_W-1:0] second_comp;
    logic or_true;
    logic or_comp;
    logic strobe_true;
    logic strobe_comp;
    logic [adc_demux_pkg::CNT_W-1:0] strobe_cnt;
    logic rst_true;
    logic rst_comp;
    logic or_event;
    logic rst_event;
  } demux_state_t;

  localparam demux_state_t DEMUX_RESET = '{
    mode: adc_demux_pkg::half_rate_mode,
    pair_phase: 1'b0,
    drop_phase: 1'b0,
    held_data: adc_demux_pkg::BYTE_ZERO,
    held_over: 1'b0,
    first_true: adc_demux_pkg::BYTE_ZERO,
    first_comp: adc_demux_pkg::BYTE_ONES,
    second_true: adc_demux_pkg::BYTE_ZERO,
    second_comp: adc_demux_pkg::BYTE_ONES,
    or_true: 1'b0,
    or_comp: 1'b1,
    strobe_true: 1'b0,
    strobe_comp: 1'b1,
    strobe_cnt: '0,
    rst_true: 1'b0,
    rst_comp: 1'b1,
    or_event: 1'b0,
    rst_event: 1'b0
  };

  demux_state_t d_reg;
  demux_state_t d_next;

  logic split_enable;
  logic second_port_enable_a;
  logic second_port_enable_b;
  logic [adc_demux_pkg::DIV_W-1:0] rate_divide_select;
  logic [1:0] pin_raw;
  logic [1:0] pin_sync_level;
  logic sync_reset_active;

  assign pin_raw = {sync_reset_input_comp, sync_reset_input_true};

  // both reset pin phases pass their own synchroniser
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_pin_sync
      pin_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in(pin_raw[gi]),
        .level_out(pin_sync_level[gi])
      );
    end
  endgenerate

  // asserted only when driven true high and complement low; self-biased open pins read low
  assign sync_reset_active = pin_sync_level[0] && !pin_sync_level[1];

  demux_apb_regs u_regs (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .mode_state(d_reg.mode),
    .sync_reset_active(sync_reset_active),
    .pair_phase(d_reg.pair_phase),
    .drop_phase(d_reg.drop_phase),
    .overrange_event(d_reg.or_event),
    .sync_reset_event(d_reg.rst_event),
    .split_enable(split_enable),
    .second_port_enable_a(second_port_enable_a),
    .second_port_enable_b(second_port_enable_b),
    .rate_divide_select(rate_divide_select)
  );

  always_comb
  begin
    adc_demux_pkg::rate_mode_t mode_now;
    logic second_on;
    logic keep;
    logic update;
    logic [adc_demux_pkg::SAMPLE_W-1:0] word_first;
    logic [adc_demux_pkg::SAMPLE_W-1:0] word_second;
    logic word_or;
    logic [adc_demux_pkg::CNT_W-1:0] extra;
    mode_now = adc_demux_pkg::decode_mode(split_enable, second_port_enable_a,
                                          second_port_enable_b,
                                          rate_divide_select);
    second_on = second_port_enable_a && second_port_enable_b;
    keep = 1'b0;
    update = 1'b0;
    word_first = d_reg.first_true;
    word_second = d_reg.second_true;
    word_or = d_reg.or_true;
    extra = adc_demux_pkg::STROBE_EXTRA_SINGLE;
    d_next = d_reg;
    d_next.mode = mode_now;
    d_next.or_event = 1'b0;
    d_next.rst_event = sync_reset_active;
    d_next.rst_true = sync_reset_active;
    d_next.rst_comp = !sync_reset_active;

    // falling edge of the strobe after its high time
    if (d_reg.strobe_cnt != '0)
      d_next.strobe_cnt = d_reg.strobe_cnt - 1'b1;
    else
      d_next.strobe_true = 1'b0;

    if (sync_reset_active || mode_now != d_reg.mode)
    begin
      // realign: next kept sample opens a new pair on the primary port
      d_next.pair_phase = 1'b0;
      d_next.drop_phase = 1'b0;
      d_next.strobe_true = 1'b0;
      d_next.strobe_cnt = '0;
    end
    else if (sample_valid)
    begin
      // each sample is taken at this clock edge
      unique case (d_reg.mode)
        adc_demux_pkg::single_port_mode:
        begin
          update = 1'b1;
          word_first = sample_data;
          word_or = sample_overrange;
          extra = adc_demux_pkg::STROBE_EXTRA_SINGLE;
        end
        adc_demux_pkg::half_rate_mode:
        begin
          keep = 1'b1;
          extra = adc_demux_pkg::STROBE_EXTRA_HALF;
        end
        adc_demux_pkg::quarter_rate_mode:
        begin
          keep = !d_reg.drop_phase;
          d_next.drop_phase = !d_reg.drop_phase;
          extra = adc_demux_pkg::STROBE_EXTRA_QUARTER;
        end
        default:
        begin
          keep = 1'b0;
        end
      endcase
      if (keep)
      begin
        if (!d_reg.pair_phase)
        begin
          d_next.held_data = sample_data;
          d_next.held_over = sample_overrange;
          d_next.pair_phase = 1'b1;
        end
        else
        begin
          // pair order fixed by phase counter, not by strobe level
          update = 1'b1;
          word_first = d_reg.held_data;
          word_second = sample_data;
          word_or = d_reg.held_over || sample_overrange;
          d_next.pair_phase = 1'b0;
        end
      end
    end

    if (update)
    begin
      // ports and strobe rise together; complements track the true phase
      d_next.first_true = word_first;
      d_next.first_comp = ~word_first;
      d_next.second_true = word_second;
      d_next.second_comp = ~word_second;
      d_next.or_true = word_or;
      d_next.or_comp = !word_or;
      d_next.or_event = word_or;
      d_next.strobe_true = 1'b1;
      d_next.strobe_cnt = extra;
    end

    // powered-down second port drives neither phase
    if (!second_on)
    begin
      d_next.second_true = adc_demux_pkg::BYTE_ZERO;
      d_next.second_comp = adc_demux_pkg::BYTE_ZERO;
    end

    // capture on complement rising equals true falling
    d_next.strobe_comp = !d_next.strobe_true;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      d_reg <= DEMUX_RESET;
    else
      d_reg <= d_next;
  end

  assign first_port_bits_true = d_reg.first_true;
  assign first_port_bits_comp = d_reg.first_comp;
  assign second_port_bits_true = d_reg.second_true;
  assign second_port_bits_comp = d_reg.second_comp;
  assign overrange_true = d_reg.or_true;
  assign overrange_comp = d_reg.or_comp;
  assign output_strobe_clock_true = d_reg.strobe_true;
  assign output_strobe_clock_comp = d_reg.strobe_comp;
  assign sync_reset_output_true = d_reg.rst_true;
  assign sync_reset_output_comp = d_reg.rst_comp;

endmodule : adc_output_demux_ctrl

//--- core/adc_demux_pkg.sv
// constants, types and mode decoding shared by the output demultiplexer files
package adc_demux_pkg;

  localparam int SAMPLE_W = 8;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int DIV_W = 3;
  localparam int CNT_W = 2;

  // register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h04;
  localparam logic [ADDR_W-1:0] EVENT_OFFSET = 8'h08;

  // control register layout
  localparam int CTRL_SPLIT_BIT = 0;
  localparam int CTRL_EN_A_BIT = 1;
  localparam int CTRL_EN_B_BIT = 2;
  localparam int CTRL_DIV_LSB = 4;
  localparam logic [DATA_W-1:0] CTRL_RESET = 32'h00000027;
  localparam logic [DATA_W-1:0] CTRL_MASK = 32'h00000077;

  // status register layout
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_SYNC_RST_BIT = 2;
  localparam int STAT_PAIR_BIT = 3;
  localparam int STAT_DROP_BIT = 4;

  // sticky event register layout, write one to clear
  localparam int EVENT_OR_BIT = 0;
  localparam int EVENT_RST_BIT = 1;
  localparam int EVENT_W = 2;

  localparam logic [DIV_W-1:0] DIV_QUARTER = 3'h4;

  // cycles the strobe stays high after an update, minus one
  localparam logic [CNT_W-1:0] STROBE_EXTRA_SINGLE = 2'h0;
  localparam logic [CNT_W-1:0] STROBE_EXTRA_HALF = 2'h0;
  localparam logic [CNT_W-1:0] STROBE_EXTRA_QUARTER = 2'h1;

  localparam logic [SAMPLE_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [SAMPLE_W-1:0] BYTE_ONES = 8'hFF;

  typedef enum logic [1:0] {
    single_port_mode = 2'b00,
    half_rate_mode = 2'b01,
    quarter_rate_mode = 2'b10
  } rate_mode_t;

  // demux only with split and both second-port enables; divide select ignored otherwise
  function automatic rate_mode_t decode_mode(
    input logic split,
    input logic en_a,
    input logic en_b,
    input logic [DIV_W-1:0] div
  );
    rate_mode_t m;
    m = single_port_mode;
    if (split && en_a && en_b)
    begin
      if (div == DIV_QUARTER)
        m = quarter_rate_mode;
      else
        m = half_rate_mode;
    end
    return m;
  endfunction : decode_mode

endpackage : adc_demux_pkg

//--- core/pin_sync.sv
// two-flop synchroniser for one pin input
`timescale 1ns/1ps
module pin_sync (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, active low
  input wire logic pin_in, // asynchronous pin level
  output logic level_out // synchronised level
);

  typedef struct packed {
    logic stage1;
    logic stage2;
  } sync_state_t;

  sync_state_t s_reg;
  sync_state_t s_next;

  always_comb
  begin
    s_next = s_reg;
    s_next.stage1 = pin_in;
    s_next.stage2 = s_reg.stage1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign level_out = s_reg.stage2;

endmodule : pin_sync

//--- core/demux_apb_regs.sv
// apb slave holding control, status and sticky event registers
`timescale 1ns/1ps
module demux_apb_regs (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [adc_demux_pkg::ADDR_W-1:0] paddr, // apb byte address
  input wire logic [adc_demux_pkg::DATA_W-1:0] pwdata, // apb write data
  output logic [adc_demux_pkg::DATA_W-1:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic [1:0] mode_state, // current rate mode
  input wire logic sync_reset_active, // demux held in reset
  input wire logic pair_phase, // pair position
  input wire logic drop_phase, // decimation position
  input wire logic overrange_event, // overranged word presented
  input wire logic sync_reset_event, // sync reset seen
  output logic split_enable, // demux enable
  output logic second_port_enable_a, // second port enable a
  output logic second_port_enable_b, // second port enable b
  output logic [adc_demux_pkg::DIV_W-1:0] rate_divide_select // divide select
);

  typedef struct packed {
    logic [adc_demux_pkg::DATA_W-1:0] ctrl;
    logic [adc_demux_pkg::EVENT_W-1:0] events;
    logic [adc_demux_pkg::DATA_W-1:0] rdata;
    logic ready;
    logic err;
  } regs_state_t;

  localparam regs_state_t REGS_RESET = '{
    ctrl: adc_demux_pkg::CTRL_RESET,
    events: '0,
    rdata: '0,
    ready: 1'b0,
    err: 1'b0
  };

  regs_state_t r_reg;
  regs_state_t r_next;

  always_comb
  begin
    logic setup;
    logic wr;
    logic [adc_demux_pkg::DATA_W-1:0] status;
    setup = psel && !penable;
    wr = psel && penable && r_reg.ready && pwrite;
    status = '0;
    status[adc_demux_pkg::STAT_MODE_LSB +: 2] = mode_state;
    status[adc_demux_pkg::STAT_SYNC_RST_BIT] = sync_reset_active;
    status[adc_demux_pkg::STAT_PAIR_BIT] = pair_phase;
    status[adc_demux_pkg::STAT_DROP_BIT] = drop_phase;
    r_next = r_reg;
    r_next.ready = setup;
    r_next.err = 1'b0;
    if (setup)
    begin
      r_next.rdata = '0;
      if (paddr == adc_demux_pkg::CTRL_OFFSET)
        r_next.rdata = r_reg.ctrl;
      else if (paddr == adc_demux_pkg::STATUS_OFFSET)
        r_next.rdata = status;
      else if (paddr == adc_demux_pkg::EVENT_OFFSET)
        r_next.rdata[adc_demux_pkg::EVENT_W-1:0] = r_reg.events;
      else
        r_next.err = 1'b1;
    end
    if (wr && paddr == adc_demux_pkg::CTRL_OFFSET)
      r_next.ctrl = pwdata & adc_demux_pkg::CTRL_MASK;
    if (wr && paddr == adc_demux_pkg::EVENT_OFFSET)
      r_next.events = r_reg.events & ~pwdata[adc_demux_pkg::EVENT_W-1:0];
    // a new event in the clearing cycle wins
    if (overrange_event)
      r_next.events[adc_demux_pkg::EVENT_OR_BIT] = 1'b1;
    if (sync_reset_event)
      r_next.events[adc_demux_pkg::EVENT_RST_BIT] = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      r_reg <= REGS_RESET;
    else
      r_reg <= r_next;
  end

  assign prdata = r_reg.rdata;
  assign pready = r_reg.ready;
  assign pslverr = r_reg.err;
  assign split_enable = r_reg.ctrl[adc_demux_pkg::CTRL_SPLIT_BIT];
  assign second_port_enable_a = r_reg.ctrl[adc_demux_pkg::CTRL_EN_A_BIT];
  assign second_port_enable_b = r_reg.ctrl[adc_demux_pkg::CTRL_EN_B_BIT];
  assign rate_divide_select = r_reg.ctrl[adc_demux_pkg::CTRL_DIV_LSB +: adc_demux_pkg::DIV_W];

endmodule : demux_apb_regs

//--- dv/adc_output_demux_ctrl_checker.sv
// port assertions for the output demultiplexer
`timescale 1ns/1ps
module adc_output_demux_ctrl_checker (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, active low
  input wire logic sync_reset_input_true, // reset pin true
  input wire logic sync_reset_input_comp, // reset pin complement
  input wire logic [adc_demux_pkg::SAMPLE_W-1:0] first_port_bits_true, // primary true
  input wire logic [adc_demux_pkg::SAMPLE_W-1:0] first_port_bits_comp, // primary complement
  input wire logic [adc_demux_pkg::SAMPLE_W-1:0] second_port_bits_true, // second true
  input wire logic [adc_demux_pkg::SAMPLE_W-1:0] second_port_bits_comp, // second complement
  input wire logic overrange_true, // overrange true
  input wire logic overrange_comp, // overrange complement
  input wire logic output_strobe_clock_true, // strobe true
  input wire logic output_strobe_clock_comp, // strobe complement
  input wire logic sync_reset_output_true, // reset out true
  input wire logic sync_reset_output_comp // reset out complement
);
  logic pin_on;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  assign pin_on = sync_reset_input_true && !sync_reset_input_comp;
  first_comp_a: assert property (first_port_bits_comp == ~first_port_bits_true)
    else $error("primary complement wrong");
  second_comp_a: assert property (second_port_bits_comp == ~second_port_bits_true ||
    (second_port_bits_comp == '0 && second_port_bits_true == '0))
    else $error("second port complement wrong");
  or_comp_a: assert property (overrange_comp == ~overrange_true)
    else $error("overrange complement wrong");
  strobe_comp_a: assert property (output_strobe_clock_comp == ~output_strobe_clock_true)
    else $error("strobe complement wrong");
  reset_comp_a: assert property (sync_reset_output_comp == ~sync_reset_output_true)
    else $error("reset output complement wrong");
  port_on_strobe_a: assert property (!$stable(first_port_bits_true) |-> output_strobe_clock_true)
    else $error("primary port changed without strobe");
  quiet_in_reset_a: assert property (sync_reset_output_true |-> !output_strobe_clock_true)
    else $error("strobe during sync reset");
  pin_reset_a: assert property (pin_on [*4] |-> sync_reset_output_true)
    else $error("reset output missing");
  pin_open_a: assert property (!pin_on [*4] |-> !sync_reset_output_true)
    else $error("reset output without pin");
endmodule : adc_output_demux_ctrl_checker

bind adc_output_demux_ctrl adc_output_demux_ctrl_checker chk (.pclk, .presetn,
  .sync_reset_input_true, .sync_reset_input_comp, .first_port_bits_true, .first_port_bits_comp,
  .second_port_bits_true, .second_port_bits_comp,
  .overrange_true, .overrange_comp, .output_strobe_clock_true, .output_strobe_clock_comp,
  .sync_reset_output_true, .sync_reset_output_comp);

//--- dv/capture_model.sv
// downstream capture logic latching both ports on the strobe
`timescale 1ns/1ps
module capture_model (
  input wire logic strobe_true, // strobe true phase
  input wire logic strobe_comp, // strobe complement phase
  input wire logic [adc_demux_pkg::SAMPLE_W-1:0] first_bits, // primary port
  input wire logic [adc_demux_pkg::SAMPLE_W-1:0] second_bits, // second port
  input wire logic overrange // overrange true
);
  logic [16:0] cap_q[$];
  logic [16:0] comp_q[$];
  always @(negedge strobe_true)
    cap_q.push_back({overrange, second_bits, first_bits});
  always @(posedge strobe_comp)
    comp_q.push_back({overrange, second_bits, first_bits});
endmodule : capture_model

//--- dv/tb_adc_output_demux_ctrl.sv
// self-checking bench for the output demultiplexer
`timescale 1ns/1ps
module tb_adc_output_demux_ctrl;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [adc_demux_pkg::ADDR_W-1:0] paddr;
  logic [adc_demux_pkg::DATA_W-1:0] pwdata, prdata, rd;
  logic sample_valid, sample_overrange, er;
  logic [adc_demux_pkg::SAMPLE_W-1:0] sample_data;
  logic sync_reset_input_true, sync_reset_input_comp;
  logic [adc_demux_pkg::SAMPLE_W-1:0] first_port_bits_true, first_port_bits_comp;
  logic [adc_demux_pkg::SAMPLE_W-1:0] second_port_bits_true, second_port_bits_comp;
  logic overrange_true, overrange_comp, output_strobe_clock_true, output_strobe_clock_comp;
  logic sync_reset_output_true, sync_reset_output_comp;
  int num_errors, samples_checked, b, c;

  adc_output_demux_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .sample_valid, .sample_data, .sample_overrange,
    .sync_reset_input_true, .sync_reset_input_comp, .first_port_bits_true,
    .first_port_bits_comp, .second_port_bits_true, .second_port_bits_comp, .overrange_true,
    .overrange_comp, .output_strobe_clock_true, .output_strobe_clock_comp,
    .sync_reset_output_true, .sync_reset_output_comp);

  capture_model cap (.strobe_true(output_strobe_clock_true),
    .strobe_comp(output_strobe_clock_comp), .first_bits(first_port_bits_true),
    .second_bits(second_port_bits_true), .overrange(overrange_true));

  task automatic wrap_up();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    samples_checked++;
    if (s !== x)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, x, s);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // ready, read data and error are taken at the rising edge that sees ready high
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (k >= 20)
    begin
      num_errors++;
      wrap_up();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask : idle

  task automatic stream(input logic [7:0] v, input int n, input int gap, input logic [7:0] orm);
    b = cap.cap_q.size();
    c = cap.comp_q.size();
    for (int i = 0; i < n; i++)
    begin
      @(posedge pclk);
      sample_valid <= 1'b1;
      sample_data <= v + 8'(i);
      sample_overrange <= orm[i];
      repeat (gap)
      begin
        @(posedge pclk);
        sample_valid <= 1'b0;
      end
    end
    @(posedge pclk);
    sample_valid <= 1'b0;
    idle(6);
  endtask : stream

  task automatic pair(input int i, input logic [16:0] x);
    chk("capture", {15'h0000, cap.cap_q[b+i]}, {15'h0000, x});
    chk("comp capture", {15'h0000, cap.comp_q[c+i]}, {15'h0000, x});
  endtask : pair

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  initial
  begin
    #400000;
    num_errors++;
    wrap_up();
  end

  initial
  begin
    {presetn, psel, penable, pwrite, sample_valid, sample_overrange} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    sample_data = 8'h00;
    sync_reset_input_true = 1'b0;
    sync_reset_input_comp = 1'b1;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, adc_demux_pkg::CTRL_OFFSET, 32'h00000000);
    chk("ctrl reset", rd, 32'h00000027);
    apb(1'b0, 8'h0C, 32'h00000000);
    chk("unmapped err", {31'h00000000, er}, 32'h00000001);
    stream(8'h10, 4, 0, 8'h08);
    pair(0, {1'b0, 8'h11, 8'h10});
    pair(1, {1'b1, 8'h13, 8'h12});
    apb(1'b1, adc_demux_pkg::CTRL_OFFSET, 32'h00000040);
    sync_reset_input_comp <= 1'b0;
    stream(8'hA0, 2, 2, 8'h01);
    pair(0, {1'b1, 8'h00, 8'hA0});
    pair(1, {1'b0, 8'h00, 8'hA1});
    chk("open pin", {31'h00000000, sync_reset_output_true}, 32'h00000000);
    sync_reset_input_comp <= 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      apb(1'b1, adc_demux_pkg::CTRL_OFFSET, (i != 0) ? 32'h00000025 : 32'h00000023);
      apb(1'b0, adc_demux_pkg::STATUS_OFFSET, 32'h00000000);
      chk("mode one enable", rd & 32'h00000003, 32'h00000000);
      chk("second off", {24'h000000, second_port_bits_comp}, 32'h00000000);
    end
    apb(1'b1, adc_demux_pkg::CTRL_OFFSET, 32'h00000047);
    idle(2);
    stream(8'h30, 8, 0, 8'h32);
    pair(0, {1'b0, 8'h32, 8'h30});
    pair(1, {1'b1, 8'h36, 8'h34});
    apb(1'b1, adc_demux_pkg::CTRL_OFFSET, 32'h00000027);
    idle(2);
    stream(8'h50, 1, 0, 8'h00);
    sync_reset_input_true <= 1'b1;
    sync_reset_input_comp <= 1'b0;
    idle(6);
    chk("reset out", {31'h00000000, sync_reset_output_true}, 32'h00000001);
    apb(1'b0, adc_demux_pkg::STATUS_OFFSET, 32'h00000000);
    chk("sync active", rd & 32'h00000004, 32'h00000004);
    sync_reset_input_true <= 1'b0;
    sync_reset_input_comp <= 1'b1;
    idle(6);
    stream(8'h60, 2, 0, 8'h00);
    pair(0, {1'b0, 8'h61, 8'h60});
    apb(1'b0, adc_demux_pkg::EVENT_OFFSET, 32'h00000000);
    chk("events", rd, 32'h00000003);
    apb(1'b1, adc_demux_pkg::EVENT_OFFSET, 32'h00000003);
    apb(1'b0, adc_demux_pkg::EVENT_OFFSET, 32'h00000000);
    chk("events cleared", rd, 32'h00000000);
    wrap_up();
  end
endmodule : tb_adc_output_demux_ctrl
